// ===== src/ess_pkg.sv
// Constants, default script image and state codes for the nonvolatile script sequencer.
package ess_pkg;

  // Register map, byte addresses on the serial control port.
  localparam logic [11:0] ESS_SCRIPT_BASE = 12'hA00;
  localparam logic [11:0] ESS_SCRIPT_LAST = 12'hAFF;
  localparam logic [11:0] ESS_STATUS_ADDR = 12'hB00;
  localparam logic [11:0] ESS_SAVE_ADDR   = 12'hB03;

  // Field positions.
  localparam int ESS_CMD_KIND_BIT = 7;
  localparam int ESS_FLAG_BIT     = 0;

  // Operation codes; any other code with the kind bit set is skipped.
  localparam logic [7:0] ESS_OP_APPLY = 8'h80;
  localparam logic [7:0] ESS_OP_END   = 8'hFF;

  // Script bytes and pointer values.
  localparam logic [7:0]  ESS_PTR_FIRST = 8'h00;
  localparam logic [7:0]  ESS_PTR_LAST  = 8'hFF;
  localparam logic [11:0] ESS_NV_FIRST  = 12'h000;

  // Values after reset.
  localparam logic       ESS_BUSY_RESET = 1'b0;
  localparam logic [7:0] ESS_RDATA_RESET = 8'h00;

  // Default script: whole register space in four 128-byte pieces and one 64-byte piece, then apply, then end.
  function automatic logic [7:0] ess_default_script(input int idx);
    logic [7:0] val;
    val = ESS_OP_END;
    case (idx)
      0, 3, 6, 9: val = 8'h7F;
      7, 10:      val = 8'h01;
      5, 11:      val = 8'h80;
      12:         val = 8'h3F;
      13:         val = 8'h02;
      15:         val = ESS_OP_APPLY;
      default:    val = (idx == 16 || idx > 16) ? ESS_OP_END : 8'h00;
    endcase
    return val;
  endfunction : ess_default_script

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    ESS_IDLE    = 7'b000_0001,
    ESS_FETCH   = 7'b000_0010,
    ESS_ADDR_HI = 7'b000_0100,
    ESS_ADDR_LO = 7'b000_1000,
    ESS_MOVE    = 7'b001_0000,
    ESS_WAIT    = 7'b010_0000,
    ESS_STEP    = 7'b100_0000
  } ess_state_t;

endpackage : ess_pkg

// ===== src/ess_cmd_decode.sv
// Classifies one script byte as transfer, apply, end or ignored operation code.
`timescale 1ns/100ps
module ess_cmd_decode (
  // Script byte.
  input  wire logic [7:0] cmd_byte,
  // Classification.
  output logic            is_xfer,
  output logic            is_apply,
  output logic            is_end,
  output logic [6:0]      xfer_len
);

  // A clear top bit means a transfer; a set bit means an operation code.
  always_comb begin
    is_xfer  = !cmd_byte[ess_pkg::ESS_CMD_KIND_BIT];
    is_apply = (cmd_byte == ess_pkg::ESS_OP_APPLY);
    is_end   = (cmd_byte == ess_pkg::ESS_OP_END);
    xfer_len = cmd_byte[6:0];
  end

endmodule : ess_cmd_decode

// ===== src/ess_sequencer.sv
// Script-driven save and restore sequencer between buffer registers and nonvolatile memory.
//
// Contract
// [RULE1] Script segment drives moves to and from storage.
// [RULE2] Clear top bit: transfer, count minus one.
// [RULE3] Two address bytes follow, high byte first.
// [RULE4] Set top bit: operation code.
// [RULE5] Only apply and end codes act.
// [RULE6] Apply code pulses the register update.
// [RULE7] End code stops the transfer.
// [RULE8] Software keeps end code in last byte.
// [RULE9] Reset script saves everything, then applies.
// [RULE10] Entries walked upward from the first byte.
// [RULE11] Save start bit launches, clears when done.
// [RULE12] Busy flag reads one while running.
`timescale 1ns/100ps
module ess_sequencer (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Register access from the serial control port.
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic [7:0]       reg_rdata,
  // Restore request from the chip's reset logic.
  input  wire logic        restore_start,
  // Buffer register bank.
  output logic [15:0]      buf_addr,
  output logic             buf_we,
  output logic [7:0]       buf_wdata,
  input  wire logic [7:0]  buf_rdata,
  output logic             io_update,
  // Nonvolatile memory.
  output logic             nv_req,
  output logic             nv_we,
  output logic [11:0]      nv_addr,
  output logic [7:0]       nv_wdata,
  input  wire logic        nv_ack,
  input  wire logic [7:0]  nv_rdata,
  // Transfer status.
  output logic             busy
);

  logic [7:0]          script [0:255];
  ess_pkg::ess_state_t state;
  ess_pkg::ess_state_t next_state;
  logic [7:0]          ptr;
  logic [7:0]          next_ptr;
  logic [6:0]          cnt;
  logic [6:0]          next_cnt;
  logic                dir_save;
  logic                next_dir_save;
  logic                next_busy;
  logic [15:0]         next_buf_addr;
  logic                next_buf_we;
  logic [7:0]          next_buf_wdata;
  logic                next_io_update;
  logic                next_nv_req;
  logic                next_nv_we;
  logic [11:0]         next_nv_addr;
  logic [7:0]          next_nv_wdata;
  logic [7:0]          next_reg_rdata;
  logic [7:0]          cur_byte;
  logic                is_xfer;
  logic                is_apply;
  logic                is_end;
  logic [6:0]          xfer_len;
  logic                script_hit;
  logic [7:0]          script_idx;
  logic                save_req;

  // The byte under the pointer is read straight from the segment.
  assign cur_byte   = script[ptr];
  assign script_hit = (reg_addr[11:8] == ess_pkg::ESS_SCRIPT_BASE[11:8]); // RULE1
  assign script_idx = reg_addr[7:0];
  assign save_req   = reg_wr_en && (reg_addr == ess_pkg::ESS_SAVE_ADDR) && reg_wdata[ess_pkg::ESS_FLAG_BIT];

  ess_cmd_decode i_ess_cmd_decode (
    .cmd_byte (cur_byte),
    .is_xfer  (is_xfer),
    .is_apply (is_apply),
    .is_end   (is_end),
    .xfer_len (xfer_len)
  );

  // Script segment; writes are blocked while a transfer walks it so entries cannot move underfoot.
  generate
    for (genvar gi = 0; gi < 256; gi++) begin : g_script
      always_ff @(posedge clk) begin
        if (reset) begin
          script[gi] <= ess_pkg::ess_default_script(gi); // RULE9
        end else if (reg_wr_en && script_hit && !busy && script_idx == 8'(gi)) begin
          script[gi] <= reg_wdata; // RULE1
        end
      end
    end
  endgenerate

  // Sequencer next-state logic.
  always_comb begin
    next_state     = state;
    next_ptr       = ptr;
    next_cnt       = cnt;
    next_dir_save  = dir_save;
    next_busy      = busy;
    next_buf_addr  = buf_addr;
    next_buf_we    = 1'b0;
    next_buf_wdata = buf_wdata;
    next_io_update = 1'b0;
    next_nv_req    = nv_req;
    next_nv_we     = nv_we;
    next_nv_addr   = nv_addr;
    next_nv_wdata  = nv_wdata;
    unique case (state)
      ess_pkg::ESS_IDLE: begin
        if (save_req || restore_start) begin
          next_state    = ess_pkg::ESS_FETCH; // RULE11
          next_busy     = 1'b1; // RULE12
          next_dir_save = save_req;
          next_ptr      = ess_pkg::ESS_PTR_FIRST; // RULE10
          next_nv_addr  = ess_pkg::ESS_NV_FIRST;
        end
      end
      ess_pkg::ESS_FETCH: begin
        // The last byte ends the walk when it is fetched as a command, which also guards against a missing end code.
        if (is_end || ptr == ess_pkg::ESS_PTR_LAST) begin
          next_state = ess_pkg::ESS_IDLE; // RULE7 RULE8
          next_busy  = 1'b0; // RULE11 RULE12
        end else if (is_xfer) begin
          next_cnt   = xfer_len; // RULE2
          next_ptr   = ptr + 8'h01; // RULE10
          next_state = ess_pkg::ESS_ADDR_HI; // RULE3
        end else begin
          next_io_update = is_apply; // RULE4 RULE5 RULE6
          next_ptr       = ptr + 8'h01; // RULE10
        end
      end
      ess_pkg::ESS_ADDR_HI: begin
        next_buf_addr[15:8] = cur_byte; // RULE3
        next_ptr            = ptr + 8'h01;
        next_state          = ess_pkg::ESS_ADDR_LO;
      end
      ess_pkg::ESS_ADDR_LO: begin
        next_buf_addr[7:0] = cur_byte; // RULE3
        next_ptr           = ptr + 8'h01;
        next_state         = ess_pkg::ESS_MOVE;
      end
      ess_pkg::ESS_MOVE: begin
        next_nv_req   = 1'b1; // RULE1
        next_nv_we    = dir_save;
        next_nv_wdata = buf_rdata;
        next_state    = ess_pkg::ESS_WAIT;
      end
      ess_pkg::ESS_WAIT: begin
        if (nv_ack) begin
          next_nv_req    = 1'b0;
          next_buf_we    = !dir_save; // RULE1
          next_buf_wdata = nv_rdata;
          next_state     = ess_pkg::ESS_STEP;
        end
      end
      ess_pkg::ESS_STEP: begin
        // Address moves only after the restore write has landed at the old address.
        next_nv_addr = nv_addr + 12'h001;
        if (cnt == 7'h00) begin
          next_state = ess_pkg::ESS_FETCH;
        end else begin
          next_cnt      = cnt - 7'h01;
          next_buf_addr = buf_addr + 16'h0001;
          next_state    = ess_pkg::ESS_MOVE;
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= ess_pkg::ESS_IDLE;
      ptr       <= ess_pkg::ESS_PTR_FIRST;
      cnt       <= 7'h00;
      dir_save  <= 1'b0;
      busy      <= ess_pkg::ESS_BUSY_RESET;
      buf_addr  <= 16'h0000;
      buf_we    <= 1'b0;
      buf_wdata <= 8'h00;
      io_update <= 1'b0;
      nv_req    <= 1'b0;
      nv_we     <= 1'b0;
      nv_addr   <= ess_pkg::ESS_NV_FIRST;
      nv_wdata  <= 8'h00;
    end else begin
      state     <= next_state;
      ptr       <= next_ptr;
      cnt       <= next_cnt;
      dir_save  <= next_dir_save;
      busy      <= next_busy;
      buf_addr  <= next_buf_addr;
      buf_we    <= next_buf_we;
      buf_wdata <= next_buf_wdata;
      io_update <= next_io_update;
      nv_req    <= next_nv_req;
      nv_we     <= next_nv_we;
      nv_addr   <= next_nv_addr;
      nv_wdata  <= next_nv_wdata;
    end
  end

  // Read data; unmapped addresses read zero.
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd_en) begin
      if (script_hit) begin
        next_reg_rdata = script[script_idx];
      end else if (reg_addr == ess_pkg::ESS_STATUS_ADDR) begin
        next_reg_rdata = {7'h00, busy}; // RULE12
      end else if (reg_addr == ess_pkg::ESS_SAVE_ADDR) begin
        next_reg_rdata = {7'h00, busy && dir_save}; // RULE11
      end else begin
        next_reg_rdata = 8'h00;
      end
    end
  end

  // Read data register.
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= ess_pkg::ESS_RDATA_RESET;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Checks on the sequencer's own behaviour.
  save_start_a: assert property (@(posedge clk) disable iff (reset) // RULE11
    (state == ess_pkg::ESS_IDLE && save_req) |=> busy && dir_save)
    else $error("save start did not launch a save");
  busy_read_a: assert property (@(posedge clk) disable iff (reset) // RULE12
    (reg_rd_en && reg_addr == ess_pkg::ESS_STATUS_ADDR) |=> reg_rdata == {7'h00, $past(busy)})
    else $error("status read does not show busy");
  end_stop_a: assert property (@(posedge clk) disable iff (reset) // RULE7
    (state == ess_pkg::ESS_FETCH && is_end) |=> state == ess_pkg::ESS_IDLE && !busy)
    else $error("end code did not stop the transfer");
  apply_pulse_a: assert property (@(posedge clk) disable iff (reset) // RULE6
    (state == ess_pkg::ESS_FETCH && is_apply && ptr != ess_pkg::ESS_PTR_LAST)
    |=> io_update ##1 (!io_update || $past(is_apply)))
    else $error("apply code did not give one update pulse");
  addr_order_a: assert property (@(posedge clk) disable iff (reset) // RULE3
    (state == ess_pkg::ESS_FETCH && is_xfer && ptr != ess_pkg::ESS_PTR_LAST)
    |=> ##2 buf_addr == {$past(script[ptr + 8'h01], 3), $past(script[ptr + 8'h02], 3)} && state == ess_pkg::ESS_MOVE)
    else $error("start address not taken high byte first");
  xfer_len_a: assert property (@(posedge clk) disable iff (reset) // RULE2
    (state == ess_pkg::ESS_FETCH && is_xfer && ptr != ess_pkg::ESS_PTR_LAST) |=> cnt == $past(cur_byte[6:0]))
    else $error("transfer count not taken from command");
  ptr_walk_a: assert property (@(posedge clk) disable iff (reset) // RULE10
    (state == ess_pkg::ESS_FETCH && !is_end && ptr != ess_pkg::ESS_PTR_LAST) |=> ptr == $past(ptr) + 8'h01)
    else $error("script pointer did not advance by one");
  opcode_kind_a: assert property (@(posedge clk) disable iff (reset) // RULE4
    (state == ess_pkg::ESS_FETCH && cur_byte[7]) |=> state != ess_pkg::ESS_ADDR_HI && !nv_req)
    else $error("operation code treated as transfer");
  restore_write_a: assert property (@(posedge clk) disable iff (reset) // RULE1
    (state == ess_pkg::ESS_WAIT && nv_ack && !dir_save) |=> buf_we && buf_wdata == $past(nv_rdata))
    else $error("restored byte not written to buffer");
  save_dir_a: assert property (@(posedge clk) disable iff (reset) // RULE1
    nv_req |-> nv_we == dir_save)
    else $error("storage direction does not match request");

  save_done_c: cover property (@(posedge clk) disable iff (reset)
    busy && dir_save ##1 !busy);
  restore_done_c: cover property (@(posedge clk) disable iff (reset)
    busy && !dir_save ##1 !busy);
  apply_seen_c: cover property (@(posedge clk) disable iff (reset) io_update);

endmodule : ess_sequencer

// ===== verif/ess_nv_model.sv
// Behavioural storage array that answers the sequencer's request and acknowledge handshake.
`timescale 1ns/100ps
module ess_nv_model (
  // Clock, reset and pace.
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  // Storage request side.
  input  wire logic        nv_req,
  input  wire logic        nv_we,
  input  wire logic [11:0] nv_addr,
  input  wire logic [7:0]  nv_wdata,
  output logic             nv_ack,
  output logic [7:0]       nv_rdata
);
  logic [7:0] mem [0:4095];
  int         wait_cnt;

  initial nv_rdata = 8'h5A;

  // Read data toggles outside the ack cycle, so a late sample sees the inverted byte instead of the stored one.
  always @(posedge clk) begin
    nv_rdata <= ~nv_rdata;
    if (reset || nv_ack || !nv_req) begin
      nv_ack   <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt < (slow ? 4 : 0)) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      nv_ack   <= 1'b1;
      nv_rdata <= mem[nv_addr];
      if (nv_we) mem[nv_addr] <= nv_wdata;
    end
  end
endmodule : ess_nv_model

// ===== verif/ess_sequencer_test.sv
// Self-checking bench for the script sequencer with a storage model and a buffer bank.
`timescale 1ns/100ps
module ess_sequencer_test;
  logic        clk, reset, reg_wr_en, reg_rd_en, restore_start, slow;
  logic [11:0] reg_addr, nv_addr;
  logic [7:0]  reg_wdata, reg_rdata, buf_wdata, buf_rdata, nv_wdata, nv_rdata, rd;
  logic [15:0] buf_addr;
  logic        buf_we, io_update, nv_req, nv_we, nv_ack, busy;
  logic [7:0]  bank [0:1023];
  int          num_errors = 0, total_checks = 0, n_upd = 0, n_buf = 0, n_nv = 0;

  ess_sequencer i_ess_sequencer (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .restore_start(restore_start),
    .buf_addr(buf_addr), .buf_we(buf_we), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
    .io_update(io_update), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .nv_ack(nv_ack), .nv_rdata(nv_rdata), .busy(busy));
  ess_nv_model i_ess_nv_model (.clk(clk), .reset(reset), .slow(slow), .nv_req(nv_req), .nv_we(nv_we),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Buffer bank reads combinationally; counters track pulses seen at the ports.
  assign buf_rdata = bank[buf_addr[9:0]];
  always @(posedge clk) begin
    if (buf_we) bank[buf_addr[9:0]] <= buf_wdata;
    n_buf <= n_buf + int'(buf_we);
    n_upd <= n_upd + int'(io_update);
    n_nv  <= n_nv + int'(nv_ack && nv_we);
  end

  task automatic test_done;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One register access; the strobe is released and a further edge passes before return.
  task automatic reg_op(input logic wr, input logic [11:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    @(posedge clk);
    #1;
    rd = reg_rdata;
  endtask : reg_op

  task automatic load_script(input logic [63:0] s);
    for (int i = 0; i < 8; i++) reg_op(1'b1, 12'hA00 + 12'(i), s[63-8*i -: 8]);
    n_upd = 0;
    n_buf = 0;
    n_nv  = 0;
  endtask : load_script

  task automatic wait_idle;
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0) begin
      num_errors++;
      $display("ERROR t=%0t busy=%h exp=%h", $time, busy, 1'b0);
      test_done;
    end
  endtask : wait_idle

  task automatic t_reset;
    check(busy, 1'b0);
    check(io_update, 1'b0);
    reg_op(1'b0, 12'hA00, 8'h00);
    check(rd, 8'h7F);
    reg_op(1'b0, 12'hA0F, 8'h00);
    check(rd, 8'h80);
    reg_op(1'b0, 12'hAFF, 8'h00);
    check(rd, 8'hFF);
    reg_op(1'b0, 12'h123, 8'h00);
    check(rd, 8'h00);
  endtask : t_reset

  // Default script saves every register byte in order and then applies once.
  task automatic t_default_save;
    n_upd = 0;
    n_nv  = 0;
    reg_op(1'b1, 12'hB03, 8'h01);
    reg_op(1'b0, 12'hB00, 8'h00);
    check(rd, 8'h01);
    reg_op(1'b0, 12'hB03, 8'h00);
    check(rd, 8'h01);
    wait_idle();
    check(16'(n_nv), 16'h0240);
    check(16'(n_upd), 16'h0001);
    check(i_ess_nv_model.mem[0], bank[0]);
    check(i_ess_nv_model.mem[575], bank[575]);
    reg_op(1'b0, 12'hB03, 8'h00);
    check(rd, 8'h00);
    reg_op(1'b0, 12'hB00, 8'h00);
    check(rd, 8'h00);
  endtask : t_default_save

  // Two-byte move, apply, then one-byte move, with a slow storage.
  task automatic t_custom_save;
    slow = 1'b1;
    load_script(64'h0102_1080_0000_30FF);
    reg_op(1'b1, 12'hB03, 8'h01);
    // A script write while the walk runs must be refused.
    reg_op(1'b1, 12'hA00, 8'h55);
    wait_idle();
    reg_op(1'b0, 12'hA00, 8'h00);
    check(rd, 8'h01);
    check(16'(n_nv), 16'h0003);
    check(i_ess_nv_model.mem[0], bank[12'h210]);
    check(i_ess_nv_model.mem[1], bank[12'h211]);
    check(i_ess_nv_model.mem[2], bank[12'h030]);
    check(16'(n_upd), 16'h0001);
  endtask : t_custom_save

  // Restore with an unknown code skipped and an entry after the end code left alone.
  task automatic t_restore;
    slow = 1'b0;
    load_script(64'h0100_4085_FF00_0050);
    i_ess_nv_model.mem[0] = 8'h3C;
    i_ess_nv_model.mem[1] = 8'hC3;
    restore_start = 1'b1;
    @(posedge clk);
    #1;
    restore_start = 1'b0;
    wait_idle();
    check(bank[12'h040], 8'h3C);
    check(bank[12'h041], 8'hC3);
    check(16'(n_upd), 16'h0000);
    check(16'(n_buf), 16'h0002);
  endtask : t_restore

  initial begin
    for (int i = 0; i < 1024; i++) bank[i] = 8'(i) ^ 8'hA5;
    reset         = 1'b1;
    reg_addr      = 12'h000;
    reg_wdata     = 8'h00;
    reg_wr_en     = 1'b0;
    reg_rd_en     = 1'b0;
    restore_start = 1'b0;
    slow          = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_default_save();
    t_custom_save();
    t_restore();
    test_done();
  end
endmodule : ess_sequencer_test
